/* File: src/frame_sequencer.sv */
// Exposure, frame-sync, trigger and image-output sequencer for a scan camera
// Contract
// [RULE1] Base frame period; reduced rate doubles output period
// [RULE2] Normal mode: continuous frame sync, image each
// [RULE3] Output starts delay after sync fall, window
// [RULE4] Reduced rate: read every sync, send alternate
// [RULE5] Long exposure: no output until exposure done
// [RULE6] Trigger mode: falling trigger edge starts event
// [RULE7] Trigger source holds input low 1 ms
// [RULE8] Flush pulse after acceptance, then exposure
// [RULE9] Internal frame sync 10 us before exposure end
// [RULE10] Trigger output uses same delay and window
// [RULE11] Inhibit from acceptance until image sent
// [RULE12] Reduced rate extends inhibit to transfer end
// [RULE13] Triggers spaced by exposure plus frame
// [RULE14] Partial region built from whole minimum units
// [RULE15] Partial scan in both modes, same rate
// [RULE16] Trigger mode on stops continuous output at once
// [RULE17] One frame exposed and sent per trigger
// [RULE18] Trigger synchronised and qualified low before accept
// [RULE19] Region past frame edge is rejected
`timescale 1ns/100ps
`include "fets_cfg.svh"
module frame_sequencer
    import fets_pkg::*;
#(
    parameter logic [31:0] FRAME_CYC     = `FRAME_CYC,
    parameter logic [31:0] OUT_DELAY_CYC = `OUT_DELAY_CYC,
    parameter logic [31:0] OUT_WIN_CYC   = `OUT_WIN_CYC,
    parameter int          FULL_W_UNITS  = `FULL_W_UNITS,
    parameter int          FULL_H_UNITS  = `FULL_H_UNITS,
    parameter int          UNIT_W        = `UNIT_W,
    parameter int          UNIT_H        = `UNIT_H
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    input  wire logic        trigger_input_n,
    output logic             frame_sync_pulse,
    output logic             charge_flush,
    output logic             exposing,
    output logic             image_active,
    output logic             trigger_inhibit,
    output logic      [15:0] roi_x0,
    output logic      [15:0] roi_width,
    output logic      [15:0] roi_y0,
    output logic      [15:0] roi_height
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (OUT_DELAY_CYC == 32'h0 || OUT_WIN_CYC == 32'h0 || FRAME_CYC < 32'h2
        || OUT_WIN_CYC > 32'h7fffffff) begin : g_chk_time
        $error("frame_sequencer: timing parameters unusable");
    end
    if (UNIT_W * FULL_W_UNITS > 65535 || UNIT_H * FULL_H_UNITS > 65535) begin : g_chk_geo
        $error("frame_sequencer: frame too large for 16-bit geometry outputs");
    end

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    localparam logic [15:0] FSYNC_W   = 16'(`FSYNC_WIDTH_CYC);
    localparam logic [31:0] FLUSH_C   = 32'(`FLUSH_CYC);
    localparam logic [31:0] LEAD_C    = 32'(`FSYNC_LEAD_CYC);
    localparam logic [31:0] QUAL_C    = 32'(`TRIG_QUAL_CYC);

    logic [3:0]             ctrl;
    logic [`SHUTTER_W-1:0]  shutter;
    logic [7:0]             reg_x, reg_w, reg_y, reg_h;
    logic                   region_err;
    logic [15:0]            image_count;
    logic                   trig_mode_d;
    logic                   trig_meta, trig_sync, trig_prev;
    logic [31:0]            frame_cnt;
    logic [31:0]            expo_acc;
    logic [15:0]            fs_cnt;
    logic [31:0]            out_cnt;
    logic [31:0]            t_cnt;
    logic                   fs_issued;
    out_state_e             out_state;
    trig_state_e            t_state;

    // ****************************************************************
    // Decoding and derived terms
    // ****************************************************************
    logic        trig_mode, reduced, iso_en, partial_en;
    logic        wr_ctrl, wr_shutter, wr_region;
    logic        fit_x, fit_y, region_ok;
    logic [31:0] exp_cyc, win_cyc, acc_sum;
    logic        trig_fall, trig_rise_mode, frame_ready;
    logic        normal_req, trig_req, fs_req, fs_fall;
    logic        start_out, out_done, expo_done;
    logic [31:0] rd_mux;

    assign trig_mode  = ctrl[`CTRL_TRIG_BIT];
    assign reduced    = ctrl[`CTRL_REDUCED_BIT];
    assign iso_en     = ctrl[`CTRL_ISO_BIT];
    assign partial_en = ctrl[`CTRL_PARTIAL_BIT];
    assign wr_ctrl    = wr_en && (addr == `REG_CTRL);
    assign wr_shutter = wr_en && (addr == `REG_SHUTTER);
    assign wr_region  = wr_en && (addr == `REG_REGION);

    // Shutter is held in microseconds; 22 bits times 100 stays inside 32 bits
    assign exp_cyc = 32'({10'h000, shutter} * 32'(`CLK_MHZ));
    // Reduced rate stretches the transfer window, which also stretches inhibit
    assign win_cyc = reduced ? {OUT_WIN_CYC[30:0], 1'b0} : OUT_WIN_CYC; // [RULE4] [RULE12]

    // Each axis checked by its own instance of the axis_fit checker
    axis_fit #(.FULL_UNITS(FULL_W_UNITS)) u_fit_x (
        .origin (wr_data[`REGION_X_LSB +: 8]),
        .size   (wr_data[`REGION_W_LSB +: 8]),
        .fits   (fit_x)
    );
    axis_fit #(.FULL_UNITS(FULL_H_UNITS)) u_fit_y (
        .origin (wr_data[`REGION_Y_LSB +: 8]),
        .size   (wr_data[`REGION_H_LSB +: 8]),
        .fits   (fit_y)
    );
    assign region_ok = fit_x && fit_y; // [RULE19]

    // Edge is looked for on the second synchroniser stage only
    assign trig_fall      = trig_prev && !trig_sync; // [RULE6]
    assign trig_rise_mode = trig_mode && !trig_mode_d;

    // Exposure spanning several frames accumulates frame periods first
    assign acc_sum     = expo_acc + FRAME_CYC;
    assign frame_ready = (acc_sum >= exp_cyc); // [RULE5]

    // Frame-sync sources: free timer in normal mode, exposure end in trigger
    assign normal_req = !trig_mode && (frame_cnt == 32'h0); // [RULE2]
    assign trig_req   = (t_state == T_EXPOSE) && !fs_issued
                        && ((t_cnt + LEAD_C) >= exp_cyc); // [RULE9]
    assign fs_req     = normal_req || trig_req;
    assign fs_fall    = (fs_cnt == 16'h0001);

    // A busy window drops the frame just read, giving alternate images
    assign start_out = fs_fall && (out_state == O_IDLE) && !trig_rise_mode
                       && (trig_mode ? (t_state == T_EXPOSE || t_state == T_WAIT)
                                     : (iso_en && frame_ready)); // [RULE4] [RULE16]
    // At-or-past end, so a rate change in mid-window can never overrun the count
    assign out_done  = (out_state == O_SEND) && (out_cnt >= win_cyc - 32'h1);
    assign expo_done = fs_issued && ((t_cnt + 32'h1) >= exp_cyc);

    // Register read selection; unmapped addresses read as zero
    assign rd_mux = (addr == `REG_CTRL)    ? {28'h0, ctrl} :
                    (addr == `REG_SHUTTER) ? {10'h0, shutter} :
                    (addr == `REG_REGION)  ? {reg_h, reg_y, reg_w, reg_x} :
                    (addr == `REG_STATUS)  ? {27'h0, out_state == O_DELAY, exposing,
                                              region_err, trigger_inhibit,
                                              image_active} :
                    (addr == `REG_IMAGES)  ? {16'h0, image_count} : 32'h0;

    // ****************************************************************
    // Register file
    // ****************************************************************
    // Rejected region writes keep the old region and raise the error flag
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl       <= `CTRL_RESET;
            shutter    <= `SHUTTER_RESET;
            reg_x      <= 8'h00;
            reg_w      <= 8'(FULL_W_UNITS);
            reg_y      <= 8'h00;
            reg_h      <= 8'(FULL_H_UNITS);
            region_err <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wr_data[3:0];
            end
            if (wr_shutter) begin
                shutter <= wr_data[`SHUTTER_W-1:0];
            end
            if (wr_region && region_ok) begin
                reg_x      <= wr_data[`REGION_X_LSB +: 8]; // [RULE14]
                reg_w      <= wr_data[`REGION_W_LSB +: 8];
                reg_y      <= wr_data[`REGION_Y_LSB +: 8];
                reg_h      <= wr_data[`REGION_H_LSB +: 8];
                region_err <= 1'b0;
            end else if (wr_region) begin
                region_err <= 1'b1; // [RULE19]
            end
        end
    end

    // Read data stands for the single cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data <= 32'h0;
        end else begin
            rd_data <= rd_en ? rd_mux : 32'h0;
        end
    end

    // ****************************************************************
    // Trigger input conditioning
    // ****************************************************************
    // Two-stage synchroniser plus edge history; idles high
    always_ff @(posedge clk) begin
        if (srst) begin
            trig_meta   <= 1'b1;
            trig_sync   <= 1'b1;
            trig_prev   <= 1'b1;
            trig_mode_d <= 1'b0;
        end else begin
            trig_meta   <= trigger_input_n; // [RULE18]
            trig_sync   <= trig_meta;
            trig_prev   <= trig_sync;
            trig_mode_d <= trig_mode;
        end
    end

    // ****************************************************************
    // Normal-mode frame timer and exposure accumulator
    // ****************************************************************
    // Sensor is read on every sync; the doubled output period of the
    // reduced rate comes from the doubled window skipping every other frame
    always_ff @(posedge clk) begin
        if (srst || trig_mode) begin
            frame_cnt <= 32'h0;
        end else if (frame_cnt == FRAME_CYC - 32'h1) begin
            frame_cnt <= 32'h0; // [RULE1]
        end else begin
            frame_cnt <= frame_cnt + 32'h1;
        end
    end

    // Counts exposed time across syncs until a whole exposure is gathered
    always_ff @(posedge clk) begin
        if (srst || trig_mode) begin
            expo_acc <= 32'h0;
        end else if (fs_fall) begin
            expo_acc <= frame_ready ? 32'h0 : acc_sum; // [RULE5]
        end
    end

    // ****************************************************************
    // Frame-sync pulse generator
    // ****************************************************************
    // A fresh request reloads the width; the falling edge is the time base
    always_ff @(posedge clk) begin
        if (srst) begin
            fs_cnt <= 16'h0;
        end else if (fs_req) begin
            fs_cnt <= FSYNC_W;
        end else if (fs_cnt != 16'h0) begin
            fs_cnt <= fs_cnt - 16'h1;
        end
    end

    // ****************************************************************
    // Image output window sequencer
    // ****************************************************************
    // Entering trigger mode aborts any window in progress
    always_ff @(posedge clk) begin
        if (srst || trig_rise_mode) begin
            out_state <= O_IDLE; // [RULE16]
            out_cnt   <= 32'h0;
        end else begin
            case (out_state)
                O_IDLE: begin
                    out_cnt <= 32'h0;
                    if (start_out) begin
                        out_state <= O_DELAY; // [RULE3] [RULE10] [RULE17]
                    end
                end
                O_DELAY: begin
                    if (out_cnt == OUT_DELAY_CYC - 32'h1) begin
                        out_state <= O_SEND;
                        out_cnt   <= 32'h0;
                    end else begin
                        out_cnt <= out_cnt + 32'h1;
                    end
                end
                O_SEND: begin
                    if (out_done) begin
                        out_state <= O_IDLE; // [RULE3]
                        out_cnt   <= 32'h0;
                    end else begin
                        out_cnt <= out_cnt + 32'h1;
                    end
                end
                default: begin
                    out_state <= O_IDLE;
                    out_cnt   <= 32'h0;
                end
            endcase
        end
    end

    // Completed images, wrapping counter for software
    always_ff @(posedge clk) begin
        if (srst) begin
            image_count <= 16'h0;
        end else if (out_done) begin
            image_count <= image_count + 16'h1;
        end
    end

    // ****************************************************************
    // Trigger sequencer
    // ****************************************************************
    // Edges seen outside idle are ignored, which is the inhibit itself
    always_ff @(posedge clk) begin
        if (srst || !trig_mode) begin
            t_state   <= T_IDLE;
            t_cnt     <= 32'h0;
            fs_issued <= 1'b0;
        end else begin
            case (t_state)
                T_IDLE: begin
                    t_cnt     <= 32'h0;
                    fs_issued <= 1'b0;
                    if (trig_fall) begin
                        t_state <= T_QUAL; // [RULE6] [RULE11]
                    end
                end
                T_QUAL: begin
                    // Bounce shorter than the qualifying time is dropped
                    if (trig_sync) begin
                        t_state <= T_IDLE; // [RULE18]
                    end else if (t_cnt == QUAL_C - 32'h1) begin
                        t_state <= T_FLUSH;
                        t_cnt   <= 32'h0;
                    end else begin
                        t_cnt <= t_cnt + 32'h1;
                    end
                end
                T_FLUSH: begin
                    if (t_cnt == FLUSH_C - 32'h1) begin
                        t_state <= T_EXPOSE; // [RULE8]
                        t_cnt   <= 32'h0;
                    end else begin
                        t_cnt <= t_cnt + 32'h1;
                    end
                end
                T_EXPOSE: begin
                    if (trig_req) begin
                        fs_issued <= 1'b1; // [RULE9]
                    end
                    if (expo_done) begin
                        t_state <= T_WAIT; // [RULE17]
                    end else begin
                        t_cnt <= t_cnt + 32'h1;
                    end
                end
                T_WAIT: begin
                    // Held until the whole image, however long, has left
                    if (fs_cnt == 16'h0 && out_state == O_IDLE) begin
                        t_state <= T_IDLE; // [RULE11] [RULE12]
                    end
                end
                default: begin
                    t_state <= T_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    // Region applies in either mode and leaves frame timing untouched
    always_ff @(posedge clk) begin
        if (srst) begin
            frame_sync_pulse <= 1'b0;
            charge_flush     <= 1'b0;
            exposing         <= 1'b0;
            image_active     <= 1'b0;
            trigger_inhibit  <= 1'b0;
            roi_x0           <= 16'h0;
            roi_width        <= 16'h0;
            roi_y0           <= 16'h0;
            roi_height       <= 16'h0;
        end else begin
            frame_sync_pulse <= (fs_cnt != 16'h0);
            charge_flush     <= (t_state == T_FLUSH); // [RULE8]
            exposing         <= (t_state == T_EXPOSE);
            image_active     <= (out_state == O_SEND);
            trigger_inhibit  <= (t_state == T_FLUSH) || (t_state == T_EXPOSE)
                                || (t_state == T_WAIT); // [RULE11]
            roi_x0     <= partial_en ? 16'(reg_x * UNIT_W) : 16'h0; // [RULE14] [RULE15]
            roi_width  <= partial_en ? 16'(reg_w * UNIT_W) : 16'(FULL_W_UNITS * UNIT_W);
            roi_y0     <= partial_en ? 16'(reg_y * UNIT_H) : 16'h0;
            roi_height <= partial_en ? 16'(reg_h * UNIT_H) : 16'(FULL_H_UNITS * UNIT_H);
        end
    end

endmodule // frame_sequencer

/* File: src/fets_cfg.svh */
// Timing, geometry and register-map constants of the frame and trigger sequencer
`ifndef FETS_CFG_SVH
`define FETS_CFG_SVH

// ****************************************************************
// Clock rate
// ****************************************************************
`define CLK_MHZ             100
`define CLK_KHZ             100000

// ****************************************************************
// Frame timing, slower variant (times as printed, cycles derived)
// ****************************************************************
`define FRAME_MS            133
`define FRAME_CYC           (`FRAME_MS * `CLK_KHZ)
`define OUT_DELAY_MS        8
`define OUT_DELAY_CYC       (`OUT_DELAY_MS * `CLK_KHZ)
`define OUT_WIN_MS          120
`define OUT_WIN_CYC         (`OUT_WIN_MS * `CLK_KHZ)

// ****************************************************************
// Trigger path timing
// ****************************************************************
`define FLUSH_US            3
`define FLUSH_CYC           (`FLUSH_US * `CLK_MHZ)
`define FSYNC_LEAD_US       10
`define FSYNC_LEAD_CYC      (`FSYNC_LEAD_US * `CLK_MHZ)
`define FSYNC_WIDTH_US      1
`define FSYNC_WIDTH_CYC     (`FSYNC_WIDTH_US * `CLK_MHZ)
`define TRIG_QUAL_US        20
`define TRIG_QUAL_CYC       (`TRIG_QUAL_US * `CLK_MHZ)

// ****************************************************************
// Partial-scan geometry
// ****************************************************************
`define UNIT_W              320
`define UNIT_H              240
`define FULL_W_UNITS        4
`define FULL_H_UNITS        4

// ****************************************************************
// Register map (byte offsets) and fields
// ****************************************************************
`define REG_CTRL            8'h00
`define REG_SHUTTER         8'h04
`define REG_REGION          8'h08
`define REG_STATUS          8'h0c
`define REG_IMAGES          8'h10
`define CTRL_TRIG_BIT       0
`define CTRL_REDUCED_BIT    1
`define CTRL_ISO_BIT        2
`define CTRL_PARTIAL_BIT    3
`define SHUTTER_W           22
`define SHUTTER_RESET       22'h000064
`define CTRL_RESET          4'h0
`define REGION_X_LSB        0
`define REGION_W_LSB        8
`define REGION_Y_LSB        16
`define REGION_H_LSB        24
`define STAT_SEND_BIT       0
`define STAT_INHIBIT_BIT    1
`define STAT_REGION_ERR_BIT 2
`define STAT_EXPOSE_BIT     3
`define STAT_DELAY_BIT      4

`endif

/* File: src/fets_pkg.sv */
// Types shared by the frame and trigger sequencer
package fets_pkg;

    // Output window sequencer, Gray along idle-delay-send
    typedef enum logic [1:0] {
        O_IDLE  = 2'b00,
        O_DELAY = 2'b01,
        O_SEND  = 2'b11
    } out_state_e;

    // Trigger sequencer, Gray along idle-qualify-flush-expose-wait
    typedef enum logic [2:0] {
        T_IDLE   = 3'b000,
        T_QUAL   = 3'b001,
        T_FLUSH  = 3'b011,
        T_EXPOSE = 3'b010,
        T_WAIT   = 3'b110
    } trig_state_e;

endpackage

/* File: src/axis_fit.sv */
// Checks that one axis of a partial-scan region fits inside the full frame
`timescale 1ns/100ps
module axis_fit #(
    parameter int FULL_UNITS = 4
) (
    input  wire logic [7:0] origin,
    input  wire logic [7:0] size,
    output logic            fits
);
    logic [8:0] extent;

    // Empty regions are refused as well as ones that run off the edge
    assign extent = {1'b0, origin} + {1'b0, size};
    assign fits   = (size != 8'h00) && (extent <= 9'(FULL_UNITS)); // [RULE19]

    if (FULL_UNITS < 1 || FULL_UNITS > 255) begin : g_chk
        $error("axis_fit: FULL_UNITS out of range");
    end
endmodule // axis_fit

/* File: test/frame_sequencer_monitor.sv */
// Port timing checker of the frame sequencer
`timescale 1ns/100ps
module frame_sequencer_monitor #(
    parameter logic [31:0] OUT_DELAY_CYC = 32'h3c
) (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        trigger_input_n,
    input wire logic        frame_sync_pulse,
    input wire logic        charge_flush,
    input wire logic        exposing,
    input wire logic        image_active,
    input wire logic        trigger_inhibit
);
    logic [31:0] since_sync;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Cycles since sync fell; saturates so long idle spans never wrap
    always_ff @(posedge clk) begin
        if (srst || frame_sync_pulse)
            since_sync <= '0;
        else if (~&since_sync)
            since_sync <= since_sync + 1'b1;
    end
    sync_width_a: assert property (
        $rose(frame_sync_pulse) |-> ##99 frame_sync_pulse ##1 !frame_sync_pulse)
        else $error("frame sync width wrong");
    flush_width_a: assert property (
        $rose(charge_flush) |-> ##299 charge_flush ##1 !charge_flush)
        else $error("flush width wrong");
    expose_after_a: assert property (
        $fell(charge_flush) |-> ##[0:1] exposing)
        else $error("no exposure after flush");
    flush_qual_a: assert property (
        $rose(charge_flush) |-> $past(trigger_input_n, 8) == 1'b0)
        else $error("flush without held trigger");
    inhibit_start_a: assert property (
        $rose(charge_flush) |-> $rose(trigger_inhibit))
        else $error("inhibit not raised at accept");
    inhibit_hold_a: assert property (
        charge_flush || exposing |-> trigger_inhibit)
        else $error("inhibit low during capture");
    inhibit_end_a: assert property (
        $fell(trigger_inhibit) |-> !image_active)
        else $error("inhibit dropped during output");
    out_delay_a: assert property (
        $rose(image_active) |-> since_sync inside {[OUT_DELAY_CYC - 3:OUT_DELAY_CYC + 3]})
        else $error("output delay wrong");
endmodule // frame_sequencer_monitor
bind frame_sequencer frame_sequencer_monitor mon (
    .clk(clk), .srst(srst), .trigger_input_n(trigger_input_n),
    .frame_sync_pulse(frame_sync_pulse), .charge_flush(charge_flush), .exposing(exposing),
    .image_active(image_active), .trigger_inhibit(trigger_inhibit));

/* File: test/trigger_source.sv */
// External trigger source model on the active-low trigger line
`timescale 1ns/100ps
module trigger_source (
    input wire logic clk,
    output logic     trig_n
);
    // Idles high as if pulled up; held low far shorter than 1 ms to keep runs short
    initial trig_n = 1'b1;
    task automatic pulse(input int low_cyc);
        @(posedge clk);
        trig_n <= 1'b0;
        repeat (low_cyc) @(posedge clk);
        trig_n <= 1'b1;
    endtask
endmodule // trigger_source

/* File: test/frame_sequencer_tb.sv */
// Self-checking bench of the frame sequencer
`timescale 1ns/100ps
`include "fets_cfg.svh"
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module frame_sequencer_tb;
    localparam int F = 1000;
    localparam int W = 900;
    logic        clk = 0;
    logic        srst = 1;
    logic [7:0]  addr = '0;
    logic [31:0] wr_data = '0;
    logic        wr_en = 0;
    logic        rd_en = 0;
    logic        rd_v = 0;
    logic        meas = 0;
    logic [31:0] rd_data;
    logic [31:0] q[$];
    logic        trig_n, fsp, flush, expo, img, inh;
    logic [15:0] rx, rw, ry, rh;
    int          num_errors = 0, checked = 0, nflush = 0, nimg = 0, x, w, y, h, t0, t1;
    always #5 clk = ~clk;
    frame_sequencer #(.FRAME_CYC(32'h3e8), .OUT_DELAY_CYC(32'h3c), .OUT_WIN_CYC(32'h384)) uut (
        .clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .trigger_input_n(trig_n), .frame_sync_pulse(fsp),
        .charge_flush(flush), .exposing(expo), .image_active(img), .trigger_inhibit(inh),
        .roi_x0(rx), .roi_width(rw), .roi_y0(ry), .roi_height(rh));
    trigger_source trig (.clk(clk), .trig_n(trig_n));
    always @(posedge flush) nflush++;
    always @(posedge img) nimg++;
    task automatic chk(input logic [31:0] got);
        logic [31:0] e;
        e = q.pop_front();
        `CMP(got, e)
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        rd_v <= rd_en;
        if (rd_v) chk(rd_data);
    end
    // Skip one window so a mode change has settled, then time the next
    initial forever begin
        wait (meas);
        @(posedge img);
        @(posedge img) t0 = $time;
        @(negedge img) t1 = $time;
        @(posedge img) meas = 0;
        chk({16'(($time - t0) / 10), 16'((t1 - t0) / 10)});
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1;
        @(posedge clk);
        wr_en <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1;
        q.push_back(e);
        @(posedge clk);
        rd_en <= 0;
    endtask
    task automatic win(input logic [31:0] c, input logic [31:0] s, input int p, input int d);
        wr(`REG_SHUTTER, s);
        wr(`REG_CTRL, c);
        q.push_back({16'(p), 16'(d)});
        meas = 1;
        wait (!meas);
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #1000000;
        num_errors++;
        end_sim;
    end
    initial begin
        x = $urandom(78873);
        repeat (8) @(posedge clk);
        srst <= 0;
        // Region outputs read zero in reset and take the full frame one edge later
        repeat (2) @(posedge clk);
        `CMP(rw, 16'(`UNIT_W * `FULL_W_UNITS))
        `CMP(rh, 16'(`UNIT_H * `FULL_H_UNITS))
        rd(`REG_CTRL, 32'h0);
        rd(`REG_SHUTTER, 32'h64);
        rd(`REG_REGION, 32'h04000400);
        rd(8'h14, 32'h0);
        x = $urandom % 4;
        w = 1 + $urandom % (4 - x);
        y = $urandom % 4;
        h = 1 + $urandom % (4 - y);
        wr(`REG_REGION, {8'(h), 8'(y), 8'(w), 8'(x)});
        wr(`REG_REGION, 32'h04000203);
        rd(`REG_STATUS, 32'h4);
        rd(`REG_REGION, {8'(h), 8'(y), 8'(w), 8'(x)});
        wr(`REG_CTRL, 32'h8);
        repeat (3) @(posedge clk);
        `CMP(rx, 16'(x * `UNIT_W))
        `CMP(rw, 16'(w * `UNIT_W))
        `CMP(ry, 16'(y * `UNIT_H))
        `CMP(rh, 16'(h * `UNIT_H))
        win(32'hc, 32'h5, F, W);
        win(32'he, 32'h5, 2 * F, 2 * W);
        win(32'hc, 32'hf, 2 * F, W);
        // Window is open now: trigger mode must cut it short
        wr(`REG_SHUTTER, 32'h1e);
        wr(`REG_CTRL, 32'hb);
        // Mode bit, then state together with its delayed copy, then the registered output
        repeat (3) @(posedge clk);
        `CMP(img, 1'b0)
        trig.pulse(500);
        repeat (3000) @(posedge clk);
        `CMP(nflush, 0)
        nimg = 0;
        fork
            trig.pulse(2500);
            begin
                @(posedge expo) t0 = $time;
                @(posedge fsp) t1 = $time;
            end
        join
        `CMP((t1 - t0) / 10 inside {[1998:2002]}, 1'b1)
        @(posedge img);
        trig.pulse(2500);
        wait (inh === 1'b0);
        repeat (3000) @(posedge clk);
        `CMP(nflush, 1)
        `CMP(nimg, 1)
        `CMP(rx, 16'(x * `UNIT_W))
        end_sim;
    end
endmodule // frame_sequencer_tb
